// ---- gbr_core.sv ----
// Stereo buzz reverb with cross-coupled feedback, treble decay, and a gate
// with lookahead on the wet path, then wet/dry mix and output gain.
// Assumes one stereo pair per in_valid pulse and a register port master.
`timescale 1ns/1ps
`default_nettype none
`include "gbr_params.svh"

module gbr_core #(
   parameter int DLY_DEPTH = 262144,
   parameter int LA_DEPTH = 2048,
   parameter int ENV_SHIFT = 6
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic in_valid,
   input wire gbr_pkg::gbr_samp_t in_l,
   input wire gbr_pkg::gbr_samp_t in_r,
   output logic out_valid,
   output gbr_pkg::gbr_samp_t out_l,
   output gbr_pkg::gbr_samp_t out_r
);
   import gbr_pkg::*;
   localparam int AW = $clog2(DLY_DEPTH);
   localparam int LW = $clog2(LA_DEPTH);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic signed [15:0] sat16(input int v);
      if (v > 32767) return 16'sh7FFF;
      if (v < -32768) return -16'sh8000;
      return 16'(v);
   endfunction

   // Scales by a percentage; used for feedback, coupling and mix.
   function automatic int pct(input int v, input int p);
      return (v * p) / `GBR_PCT_MAX;
   endfunction

   function automatic int mag(input int v);
      return (v < 0) ? -v : v;
   endfunction

   // Tenths of a millisecond to whole samples, clamped to a depth.
   function automatic int tenths_to_samp(input int t, input int lim);
      int s;
      s = (t * `GBR_SAMP_PER_MS) / 10;
      if (s < 0) s = 0;
      if (s > lim) s = lim;
      return s;
   endfunction

   // ****************************************
   // Register file
   // ****************************************
   logic [4:0] ctrl_q;
   logic [6:0] mix_q, fdbk_q, xcpl_q;
   logic [15:0] gain_q, damp_q, thresh_q, atk_q, rel_q;
   logic [12:0] coarse_q;
   logic signed [8:0] fine_q;
   logic [7:0] spacing_q, lookahead_q;
   logic [9:0] contour_q;
   logic [11:0] hold_q;
   gbr_gate_t gate_q;
   logic [16:0] gate_gain_q;
   logic [17:0] hold_cnt_q;
   logic above_q;

   // Percent fields saturate at 100 so the scaling never exceeds unity.
   function automatic logic [6:0] clip_pct(input logic [31:0] w);
      return (w > 32'd100) ? 7'd100 : w[6:0];
   endfunction

   // Writes land between ticks; the sample path reads them only at a tick.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= 5'h00;
         mix_q <= `GBR_RST_MIX;
         gain_q <= `GBR_RST_GAIN;
         fdbk_q <= 7'h00;
         xcpl_q <= 7'h00;
         damp_q <= `GBR_DAMP_NONE;
         coarse_q <= `GBR_RST_COARSE;
         fine_q <= 9'sh000;
         spacing_q <= 8'h00;
         contour_q <= 10'h000;
         thresh_q <= 16'h0100;
         hold_q <= `GBR_RST_HOLD;
         atk_q <= 16'h0000;
         rel_q <= 16'h0000;
         lookahead_q <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            `GBR_OFF_CTRL: ctrl_q <= reg_wdata[4:0];
            `GBR_OFF_MIX: mix_q <= clip_pct(reg_wdata);
            `GBR_OFF_GAIN: gain_q <= reg_wdata[15:0];
            `GBR_OFF_FDBK: fdbk_q <= clip_pct(reg_wdata);
            `GBR_OFF_XCPL: xcpl_q <= clip_pct(reg_wdata);
            `GBR_OFF_DAMP: damp_q <= reg_wdata[15:0];
            `GBR_OFF_COARSE: coarse_q <= reg_wdata[12:0];
            `GBR_OFF_FINE: fine_q <= reg_wdata[8:0];
            `GBR_OFF_SPACING: spacing_q <= reg_wdata[7:0];
            `GBR_OFF_CONTOUR: contour_q <= reg_wdata[9:0];
            `GBR_OFF_THRESH: thresh_q <= reg_wdata[15:0];
            `GBR_OFF_HOLD: hold_q <= reg_wdata[11:0];
            `GBR_OFF_ATK: atk_q <= reg_wdata[15:0];
            `GBR_OFF_REL: rel_q <= reg_wdata[15:0];
            `GBR_OFF_LOOKAHD: lookahead_q <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         case (reg_addr)
            `GBR_OFF_CTRL: reg_rdata <= {27'h0, ctrl_q};
            `GBR_OFF_MIX: reg_rdata <= {25'h0, mix_q};
            `GBR_OFF_GAIN: reg_rdata <= {16'h0, gain_q};
            `GBR_OFF_FDBK: reg_rdata <= {25'h0, fdbk_q};
            `GBR_OFF_XCPL: reg_rdata <= {25'h0, xcpl_q};
            `GBR_OFF_DAMP: reg_rdata <= {16'h0, damp_q};
            `GBR_OFF_COARSE: reg_rdata <= {19'h0, coarse_q};
            `GBR_OFF_FINE: reg_rdata <= {23'h0, fine_q};
            `GBR_OFF_SPACING: reg_rdata <= {24'h0, spacing_q};
            `GBR_OFF_CONTOUR: reg_rdata <= {22'h0, contour_q};
            `GBR_OFF_THRESH: reg_rdata <= {16'h0, thresh_q};
            `GBR_OFF_HOLD: reg_rdata <= {20'h0, hold_q};
            `GBR_OFF_ATK: reg_rdata <= {16'h0, atk_q};
            `GBR_OFF_REL: reg_rdata <= {16'h0, rel_q};
            `GBR_OFF_LOOKAHD: reg_rdata <= {24'h0, lookahead_q};
            `GBR_OFF_STATUS: reg_rdata <= {12'h0, above_q, gate_q,
                                           gate_gain_q};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Reverb loop
   // ****************************************
   logic signed [15:0] dl_l [DLY_DEPTH];
   logic signed [15:0] dl_r [DLY_DEPTH];
   logic [AW-1:0] wr_q;
   logic signed [15:0] lp_l_q, lp_r_q;
   int dly_s, tap_s;
   logic signed [15:0] rev_l, rev_r, feed_l, feed_r, lp_l_d, lp_r_d;

   // Whole sample path settles in one cycle, so no sample sees mixed
   // settings. The early tap sits a quarter spacing (spacing_q[7:2] samples)
   // short of the main tap; each loop pass adds one more impulse to the cluster, still one such step apart.
   always_comb begin
      int sum_l, sum_r, e_l, e_r;
      dly_s = tenths_to_samp(int'(coarse_q) * 10 + int'(fine_q),
                             DLY_DEPTH - 1);
      if (dly_s < 1) dly_s = 1;
      tap_s = int'(spacing_q[7:2]);
      tap_s = (dly_s > tap_s) ? dly_s - tap_s : dly_s;
      e_l = (int'(dl_l[wr_q - AW'(tap_s)]) * int'(contour_q))
            / `GBR_CONTOUR_MAX;
      e_r = (int'(dl_r[wr_q - AW'(tap_s)]) * int'(contour_q))
            / `GBR_CONTOUR_MAX;
      rev_l = sat16(int'(dl_l[wr_q - AW'(dly_s)]) + e_l);
      rev_r = sat16(int'(dl_r[wr_q - AW'(dly_s)]) + e_r);
      sum_l = int'(in_l) + pct(int'(lp_l_q), int'(fdbk_q));
      sum_r = int'(in_r) + pct(int'(lp_r_q), int'(fdbk_q));
      feed_l = sat16(pct(sum_l, `GBR_PCT_MAX - int'(xcpl_q))
                     + pct(sum_r, int'(xcpl_q)));
      feed_r = sat16(pct(sum_r, `GBR_PCT_MAX - int'(xcpl_q))
                     + pct(sum_l, int'(xcpl_q)));
      if (damp_q == `GBR_DAMP_NONE) begin
         lp_l_d = rev_l;
         lp_r_d = rev_r;
      end else begin
         lp_l_d = sat16(int'(lp_l_q) + (((int'(rev_l) - int'(lp_l_q))
                  * int'(damp_q)) >>> 16));
         lp_r_d = sat16(int'(lp_r_q) + (((int'(rev_r) - int'(lp_r_q))
                  * int'(damp_q)) >>> 16));
      end
   end

   // Delay lines have no reset; stale content decays through the loop.
   always_ff @(posedge mclk) begin
      if (in_valid) begin
         dl_l[wr_q] <= feed_l;
         dl_r[wr_q] <= feed_r;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_q <= '0;
         lp_l_q <= 16'sh0000;
         lp_r_q <= 16'sh0000;
      end else if (in_valid) begin
         wr_q <= wr_q + 1'b1;
         lp_l_q <= lp_l_d;
         lp_r_q <= lp_r_d;
      end
   end

   // ****************************************
   // Side-chain envelope and gate
   // ****************************************
   logic [15:0] env_q, rect;
   logic above;
   logic [17:0] hold_samp;

   // A peak follower gives a fast rise and a slow fall, so short gaps in
   // the side-chain do not chatter the threshold compare.
   always_comb begin
      int sl, sr;
      sl = ctrl_q[`GBR_CTRL_TAP] ? int'(rev_l) : int'(in_l);
      sr = ctrl_q[`GBR_CTRL_TAP] ? int'(rev_r) : int'(in_r);
      case (ctrl_q[`GBR_CTRL_CHAN_HI:`GBR_CTRL_CHAN_LO])
         2'b00: rect = 16'(mag(sl) > 32767 ? 32767 : mag(sl));
         2'b01: rect = 16'(mag(sr) > 32767 ? 32767 : mag(sr));
         default: rect = 16'((mag(sl) + mag(sr)) / 2);
      endcase
      above = (env_q > thresh_q);
      hold_samp = 18'(int'(hold_q) * `GBR_SAMP_PER_MS);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         env_q <= 16'h0000;
         above_q <= 1'b0;
      end else if (in_valid) begin
         if (rect > env_q) env_q <= rect;
         else env_q <= env_q - (env_q >> ENV_SHIFT);
         above_q <= above;
      end
   end

   // The gain runs toward active on a crossing and back after the hold.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         gate_q <= G_CLOSED;
         gate_gain_q <= 17'h00000;
         hold_cnt_q <= 18'h00000;
      end else if (in_valid) begin
         if (hold_cnt_q != 18'h0) hold_cnt_q <= hold_cnt_q - 1'b1;
         if (above) hold_cnt_q <= hold_samp;
         case (gate_q)
            G_CLOSED: begin
               if (above) gate_q <= G_ATTACK;
            end
            G_ATTACK: begin
               if (atk_q == 16'h0 ||
                   gate_gain_q + atk_q >= `GBR_GATE_FULL) begin
                  gate_gain_q <= `GBR_GATE_FULL;
                  gate_q <= G_HOLD;
               end else begin
                  gate_gain_q <= gate_gain_q + atk_q;
               end
            end
            G_HOLD: begin
               if (!above && hold_cnt_q == 18'h0) gate_q <= G_RELEASE;
            end
            G_RELEASE: begin
               if (above) begin
                  gate_q <= G_ATTACK;
               end else if (rel_q == 16'h0 || gate_gain_q <= rel_q) begin
                  gate_gain_q <= 17'h00000;
                  gate_q <= G_CLOSED;
               end else begin
                  gate_gain_q <= gate_gain_q - rel_q;
               end
            end
            default: gate_q <= G_CLOSED;
         endcase
      end
   end

   // ****************************************
   // Lookahead, gate gain, mix and output
   // ****************************************
   logic signed [15:0] la_l [LA_DEPTH];
   logic signed [15:0] la_r [LA_DEPTH];
   logic [LW-1:0] la_wr_q;
   logic [16:0] gain_app;
   logic signed [15:0] wet_l, wet_r, o_l_d, o_r_d;

   always_ff @(posedge mclk) begin
      if (in_valid) begin
         la_l[la_wr_q] <= rev_l;
         la_r[la_wr_q] <= rev_r;
      end
   end

   // Only the wet path passes the lookahead and the gate; the dry input
   // goes straight to the mix.
   always_comb begin
      int la_s, ml, mr;
      logic signed [15:0] dw_l, dw_r;
      la_s = tenths_to_samp(int'(lookahead_q), LA_DEPTH - 1);
      dw_l = (la_s == 0) ? rev_l : la_l[la_wr_q - LW'(la_s)];
      dw_r = (la_s == 0) ? rev_r : la_r[la_wr_q - LW'(la_s)];
      if (!ctrl_q[`GBR_CTRL_GATE]) gain_app = `GBR_GATE_FULL;
      else if (ctrl_q[`GBR_CTRL_DUCK])
         gain_app = `GBR_GATE_FULL - gate_gain_q;
      else gain_app = gate_gain_q;
      wet_l = sat16((int'(dw_l) * int'(gain_app)) >>> 16);
      wet_r = sat16((int'(dw_r) * int'(gain_app)) >>> 16);
      ml = pct(int'(wet_l), int'(mix_q))
           + pct(int'(in_l), `GBR_PCT_MAX - int'(mix_q));
      mr = pct(int'(wet_r), int'(mix_q))
           + pct(int'(in_r), `GBR_PCT_MAX - int'(mix_q));
      o_l_d = sat16((ml * int'(gain_q)) >>> 12);
      o_r_d = sat16((mr * int'(gain_q)) >>> 12);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         la_wr_q <= '0;
         out_valid <= 1'b0;
         out_l <= 16'sh0000;
         out_r <= 16'sh0000;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            la_wr_q <= la_wr_q + 1'b1;
            out_l <= o_l_d;
            out_r <= o_r_d;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   property p_dry_bypass;
      in_valid && mix_q == 7'd0 && gain_q == `GBR_GAIN_UNITY
         |=> out_valid && out_l == $past(in_l) && out_r == $past(in_r);
   endproperty
   a_dry_bypass: assert property (p_dry_bypass)
      else $error("Dry path not bypassing the gate.");

   property p_mute;
      in_valid && gain_q == 16'h0 |=> out_l == 16'sh0 && out_r == 16'sh0;
   endproperty
   a_mute: assert property (p_mute)
      else $error("Zero output gain did not mute.");

   property p_one_per_tick;
      out_valid == $past(in_valid);
   endproperty
   a_one_per_tick: assert property (p_one_per_tick)
      else $error("Output strobe not one cycle after input strobe.");

   property p_hold_restart;
      in_valid && above |=> hold_cnt_q == $past(hold_samp);
   endproperty
   a_hold_restart: assert property (p_hold_restart)
      else $error("Hold timer not restarted on crossing.");

   property p_hold_expire;
      in_valid && gate_q == G_HOLD && !above && hold_cnt_q == 18'h0
         |=> gate_q == G_RELEASE;
   endproperty
   a_hold_expire: assert property (p_hold_expire)
      else $error("Gate did not start release at hold expiry.");

   property p_open_on_cross;
      in_valid && gate_q == G_CLOSED && above |=> gate_q == G_ATTACK;
   endproperty
   a_open_on_cross: assert property (p_open_on_cross)
      else $error("Crossing did not start the attack.");

   property p_release_falls;
      in_valid && gate_q == G_RELEASE && !above
         |=> gate_gain_q < $past(gate_gain_q) || gate_gain_q == 17'h0;
   endproperty
   a_release_falls: assert property (p_release_falls)
      else $error("Release did not lower the gate gain.");

   property p_attack_rises;
      in_valid && gate_q == G_ATTACK |=> gate_gain_q > $past(gate_gain_q)
         || gate_gain_q == `GBR_GATE_FULL;
   endproperty
   a_attack_rises: assert property (p_attack_rises)
      else $error("Attack did not raise the gate gain.");

   property p_gate_bypass;
      !ctrl_q[`GBR_CTRL_GATE] |-> gain_app == `GBR_GATE_FULL;
   endproperty
   a_gate_bypass: assert property (p_gate_bypass)
      else $error("Gate switch off but gate gain applied.");

   property p_ptr_step;
      in_valid |=> wr_q == $past(wr_q) + 1'b1;
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("Delay line pointer did not step per sample.");

   c_attack: cover property (gate_q == G_CLOSED ##1 gate_q == G_ATTACK);
   c_release_done: cover property (gate_q == G_RELEASE ##1
                                   gate_q == G_CLOSED);
   c_duck: cover property (ctrl_q[`GBR_CTRL_DUCK] && gate_q == G_HOLD);
   c_avg_chan: cover property (ctrl_q[`GBR_CTRL_CHAN_HI] && above);
endmodule
`default_nettype wire

// ---- gbr_params.svh ----
// Constants of the gated buzz reverb: register offsets, field positions,
// reset values and sample-rate figures.
// Assumes inclusion by bare name from the core and the bench.
`ifndef GBR_PARAMS_SVH
`define GBR_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define GBR_OFF_CTRL     8'h00
`define GBR_OFF_MIX      8'h04
`define GBR_OFF_GAIN     8'h08
`define GBR_OFF_FDBK     8'h0C
`define GBR_OFF_XCPL     8'h10
`define GBR_OFF_DAMP     8'h14
`define GBR_OFF_COARSE   8'h18
`define GBR_OFF_FINE     8'h1C
`define GBR_OFF_SPACING  8'h20
`define GBR_OFF_CONTOUR  8'h24
`define GBR_OFF_THRESH   8'h28
`define GBR_OFF_HOLD     8'h2C
`define GBR_OFF_ATK      8'h30
`define GBR_OFF_REL      8'h34
`define GBR_OFF_LOOKAHD  8'h38
`define GBR_OFF_STATUS   8'h3C

// ****************************************
// Control fields
// ****************************************
`define GBR_CTRL_GATE    0
`define GBR_CTRL_DUCK    1
`define GBR_CTRL_CHAN_LO 2
`define GBR_CTRL_CHAN_HI 3
`define GBR_CTRL_TAP     4

// ****************************************
// Reset values and scales
// ****************************************
`define GBR_RST_MIX      7'h32
`define GBR_RST_GAIN     16'h1000
`define GBR_GAIN_UNITY   16'h1000
`define GBR_DAMP_NONE    16'hFFFF
`define GBR_RST_COARSE   13'h01F4
`define GBR_RST_HOLD     12'h0064
`define GBR_PCT_MAX      100
`define GBR_CONTOUR_MAX  1000
`define GBR_GATE_FULL    17'h10000

// ****************************************
// Timing
// ****************************************
`define GBR_CLK_NS       10
`define GBR_FS_HZ        48000
`define GBR_SAMP_PER_MS  (`GBR_FS_HZ / 1000)

`endif

// ---- gbr_pkg.sv ----
// Types shared by the gated buzz reverb.
// Assumes nothing beyond a SystemVerilog compiler.
package gbr_pkg;
   typedef logic signed [15:0] gbr_samp_t;
   typedef enum logic [1:0] {
      G_CLOSED  = 2'b00,
      G_ATTACK  = 2'b01,
      G_HOLD    = 2'b10,
      G_RELEASE = 2'b11
   } gbr_gate_t;
endpackage

// ---- gbr_stream_peer.sv ----
// Upstream sample source and downstream sink for the reverb core.
// Assumes the core answers each sample tick exactly one cycle later.
`timescale 1ns/1ps
`default_nettype none

module gbr_stream_peer (
   input wire logic mclk,
   output logic in_valid,
   output var gbr_pkg::gbr_samp_t in_l,
   output var gbr_pkg::gbr_samp_t in_r,
   input wire logic out_valid,
   input wire gbr_pkg::gbr_samp_t out_l,
   input wire gbr_pkg::gbr_samp_t out_r
);
   import gbr_pkg::*;
   // ********************
   // Sample exchange
   // ********************
   // The source is idle until the first call.
   initial begin
      in_valid = 1'b0;
      in_l = 16'sh0000;
      in_r = 16'sh0000;
   end
   // One pair per call; idle lines carry the inverse, so a core that
   // samples without the tick picks up garbage rather than a stale copy.
   task automatic send(input gbr_samp_t l, input gbr_samp_t r,
         output gbr_samp_t ol, output gbr_samp_t orr, output logic ok);
      @(posedge mclk);
      in_valid <= 1'b1;
      in_l <= l;
      in_r <= r;
      @(posedge mclk);
      in_valid <= 1'b0;
      in_l <= ~l;
      in_r <= ~r;
      #1;
      ok = (out_valid === 1'b1);
      ol = out_l;
      orr = out_r;
   endtask
endmodule
`default_nettype wire

// ---- gated_buzz_reverb_tb.sv ----
// Self-checking bench for the reverb core, driven through the stream peer.
// Assumes short delay memories and the register map of the core.
`timescale 1ns/1ps
`default_nettype none
`include "gbr_params.svh"

module gated_buzz_reverb_tb;
   import gbr_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] d;
   logic in_valid, out_valid, ok;
   gbr_samp_t in_l, in_r, out_l, out_r, ol, orr;
   int n_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int idx, cl, cr;
   // ********************
   // Clock, timeout and instances
   // ********************
   // Free-running clock; the ceiling is nearly four times the planned run.
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         $display("[FAIL] %0t run hung", $time);
         give_verdict();
      end
   end
   gbr_core #(.DLY_DEPTH(1024), .LA_DEPTH(256)) i_gbr_core (.mclk(mclk),
      .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .in_valid(in_valid), .in_l(in_l), .in_r(in_r),
      .out_valid(out_valid), .out_l(out_l), .out_r(out_r));
   gbr_stream_peer i_gbr_stream_peer (.mclk(mclk), .in_valid(in_valid),
      .in_l(in_l), .in_r(in_r), .out_valid(out_valid), .out_l(out_l),
      .out_r(out_r));
   // ********************
   // Shared tasks
   // ********************
   task chk(input logic c, input string msg);
      num_checks++;
      if (c !== 1'b1) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so grab them there.
   task rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task tick(input gbr_samp_t l, input gbr_samp_t r);
      i_gbr_stream_peer.send(l, r, ol, orr, ok);
      chk(ok, "sample answer missing");
   endtask
   task settle(input int n);
      repeat (n) tick(16'sh0000, 16'sh0000);
   endtask
   // Impulse on the left, then silence; records where loud samples land.
   task probe(input gbr_samp_t amp, input int n);
      idx = -1;
      cl = 0;
      cr = 0;
      for (int i = 0; i < n; i++) begin
         tick((i == 0) ? amp : 16'sh0000, 16'sh0000);
         if (ol > 16'sh0800) begin
            cl++;
            if (idx < 0) idx = i;
         end
         if (orr > 16'sh0800) cr++;
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ********************
   // Scenarios
   // ********************
   task t_reset;
      logic [7:0] a [8];
      logic [31:0] e [8];
      a = '{`GBR_OFF_CTRL, `GBR_OFF_MIX, `GBR_OFF_GAIN, `GBR_OFF_DAMP,
         `GBR_OFF_COARSE, `GBR_OFF_HOLD, `GBR_OFF_THRESH, 8'h40};
      e = '{32'h0, 32'h32, 32'h1000, 32'hFFFF, 32'h1F4, 32'h64, 32'h100, 0};
      wr(8'h40, 32'hFFFF);
      for (int i = 0; i < 8; i++) begin
         rd(a[i]);
         chk(d === e[i], "reset value");
      end
      // Read data must fall back to zero one cycle after it stood.
      @(posedge mclk);
      #1;
      chk(reg_rdata === 32'h0, "read data cleared");
      $display("reset values done");
   endtask
   // Gate shut hard; dry, mix and gain must show no trace of it.
   task t_dry;
      wr(`GBR_OFF_CTRL, 32'h1);
      wr(`GBR_OFF_THRESH, 32'h7FFF);
      wr(`GBR_OFF_MIX, 32'h0);
      tick(16'sh3000, -16'sh1000);
      chk(ol === 16'sh3000 && orr === -16'sh1000, "dry path");
      wr(`GBR_OFF_MIX, 32'd50);
      tick(16'sh4000, 16'sh4000);
      chk(ol === 16'sh2000, "half mix");
      wr(`GBR_OFF_GAIN, 32'h0);
      tick(16'sh4000, 16'sh4000);
      chk(ol === 16'sh0000, "muted");
      wr(`GBR_OFF_GAIN, 32'h2000);
      wr(`GBR_OFF_MIX, 32'h0);
      tick(16'sh3000, 16'sh5000);
      chk(ol === 16'sh6000 && orr === 16'sh7FFF, "gain x2");
      wr(`GBR_OFF_GAIN, 32'h1000);
      $display("dry and gain done");
   endtask
   task t_delay;
      wr(`GBR_OFF_CTRL, 32'h0);
      wr(`GBR_OFF_MIX, 32'd100);
      wr(`GBR_OFF_COARSE, 32'h1);
      // Flush the last loud dry ticks out of the now short delay window.
      settle(60);
      probe(16'sh4000, 60);
      chk(idx == 48 && cl == 1 && cr == 0, "1 ms echo");
      wr(`GBR_OFF_FINE, 32'h1FB);
      probe(16'sh4000, 60);
      chk(idx == 24, "fine offset");
      wr(`GBR_OFF_FINE, 32'h0);
      wr(`GBR_OFF_XCPL, 32'd100);
      probe(16'sh4000, 60);
      chk(cl == 0 && cr == 1, "cross-coupled");
      wr(`GBR_OFF_XCPL, 32'h0);
      wr(`GBR_OFF_FDBK, 32'd50);
      probe(16'sh4000, 110);
      chk(cl == 2, "feedback repeat");
      wr(`GBR_OFF_FDBK, 32'h0);
      settle(300);
      // Full contour adds an early tap a quarter spacing (16 samples) short.
      wr(`GBR_OFF_CONTOUR, 32'd1000);
      wr(`GBR_OFF_SPACING, 32'h40);
      probe(16'sh4000, 60);
      chk(idx == 32 && cl == 2, "early tap");
      wr(`GBR_OFF_CONTOUR, 32'h0);
      wr(`GBR_OFF_SPACING, 32'h0);
      $display("delay line done");
   endtask
   task t_gate;
      wr(`GBR_OFF_CTRL, 32'h1);
      probe(16'sh1000, 60);
      chk(cl == 0, "gate closed");
      wr(`GBR_OFF_CTRL, 32'h3);
      probe(16'sh1000, 60);
      chk(idx == 48, "ducked open");
      wr(`GBR_OFF_CTRL, 32'h1);
      wr(`GBR_OFF_THRESH, 32'h100);
      wr(`GBR_OFF_HOLD, 32'h2);
      wr(`GBR_OFF_LOOKAHD, 32'd10);
      // The lookahead memory still holds the ducked echo; flush it first.
      settle(60);
      probe(16'sh4000, 110);
      chk(idx == 96, "lookahead");
      wr(`GBR_OFF_LOOKAHD, 32'h0);
      wr(`GBR_OFF_ATK, 32'h1000);
      settle(1000);
      rd(`GBR_OFF_STATUS);
      chk(d[19:0] === 20'h0, "closed at rest");
      // The envelope registers on one tick and is compared on the next.
      repeat (2) tick(16'sh4000, 16'sh0000);
      rd(`GBR_OFF_STATUS);
      chk(d[19:17] === 3'b101, "attack");
      repeat (20) tick(16'sh4000, 16'sh0000);
      rd(`GBR_OFF_STATUS);
      chk(d[19:0] === 20'hD0000, "hold full");
      settle(1000);
      rd(`GBR_OFF_STATUS);
      chk(d[18:0] === 19'h0, "released");
      $display("gate done");
   endtask
   task t_side;
      wr(`GBR_OFF_CTRL, 32'h5);
      repeat (4) tick(16'sh4000, 16'sh0000);
      rd(`GBR_OFF_STATUS);
      chk(d[19] === 1'b0, "right ignores left");
      wr(`GBR_OFF_CTRL, 32'h9);
      repeat (2) tick(16'sh4000, 16'sh0000);
      rd(`GBR_OFF_STATUS);
      chk(d[19] === 1'b1, "mean of both");
      settle(1000);
      wr(`GBR_OFF_CTRL, 32'h11);
      repeat (4) tick(16'sh4000, 16'sh0000);
      rd(`GBR_OFF_STATUS);
      chk(d[19] === 1'b0, "output tap quiet");
      settle(50);
      rd(`GBR_OFF_STATUS);
      chk(d[19] === 1'b1, "output tap tail");
      $display("side-chain done");
   endtask
   // Main sequence: reset, flush the memories, then the scenarios.
   initial begin
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      settle(1100);
      t_dry();
      t_delay();
      t_gate();
      t_side();
      give_verdict();
   end
endmodule
`default_nettype wire
